// >>> fbpcc_defs.vh
// Constants for the flash byte program host controller.
`ifndef FBPCC_DEFS_VH
`define FBPCC_DEFS_VH
`define FBPCC_CLK_NS 4
`define FBPCC_CMD_READ 8'h00
`define FBPCC_CMD_SETUP_PROG 8'h40
`define FBPCC_CMD_PROG_VERIFY 8'hC0
`define FBPCC_CMD_SETUP_ERASE 8'h20
`define FBPCC_CMD_ERASE_VERIFY 8'hA0
`define FBPCC_CMD_RESET 8'hFF
`define FBPCC_CMD_AUTOSEL 8'h90
`define FBPCC_ERASED 8'hFF
`define FBPCC_PROG_PULSE_NS 10000
`define FBPCC_ERASE_PULSE_NS 10000000
`define FBPCC_RECOVERY_NS 6000
`define FBPCC_SUPPLY_SETTLE_NS 100
`define FBPCC_PROG_CYC ((`FBPCC_PROG_PULSE_NS + `FBPCC_CLK_NS - 1) / `FBPCC_CLK_NS)
`define FBPCC_ERASE_CYC ((`FBPCC_ERASE_PULSE_NS + `FBPCC_CLK_NS - 1) / `FBPCC_CLK_NS)
`define FBPCC_RECOVERY_CYC ((`FBPCC_RECOVERY_NS + `FBPCC_CLK_NS - 1) / `FBPCC_CLK_NS)
`define FBPCC_SETTLE_CYC ((`FBPCC_SUPPLY_SETTLE_NS + `FBPCC_CLK_NS - 1) / `FBPCC_CLK_NS)
`define FBPCC_MAX_PROG_PULSES 5'h19
`define FBPCC_MAX_ERASE_PULSES 10'h03E8
`define FBPCC_STROBE_CYC 5'h0F
`endif

// >>> fbpcc_bus_cycle.v
// One strobed write or read cycle on the flash pins.
`timescale 1ns/10ps
module fbpcc_bus_cycle
(
    input wire clock_i,
    input wire rst_n_i,
    input wire start_i,
    input wire write_i,
    input wire [15:0] addr_i,
    input wire [7:0] wdata_i,
    output wire busy_o,
    output reg done_o,
    output reg [7:0] rdata_o,
    output reg [15:0] flash_addr_o,
    output reg [7:0] flash_data_o,
    output reg flash_data_oe_o,
    input wire [7:0] flash_data_i,
    output reg flash_ce_n_o,
    output reg flash_we_n_o,
    output reg flash_oe_n_o
);
`include "fbpcc_defs.vh"
    // Strobe is held low for a fixed count; generous versus the slowest part.
    reg [4:0] cnt_q;
    reg active_q;
    reg wr_q;
    reg [7:0] sync1_q;
    reg [7:0] sync2_q;
    assign busy_o = active_q;
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end
        else
        begin
            sync1_q <= flash_data_i;
            sync2_q <= sync1_q;
        end
    end
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 5'h00;
            active_q <= 1'b0;
            wr_q <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            flash_addr_o <= 16'h0000;
            flash_data_o <= 8'h00;
            flash_data_oe_o <= 1'b0;
            flash_ce_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
        end
        else
        begin
            done_o <= 1'b0;
            if (!active_q && start_i)
            begin
                active_q <= 1'b1;
                wr_q <= write_i;
                cnt_q <= 5'h00;
                flash_addr_o <= addr_i;
                flash_data_o <= wdata_i;
                flash_data_oe_o <= write_i;
                flash_ce_n_o <= 1'b0;
                flash_we_n_o <= ~write_i;
                flash_oe_n_o <= write_i;
            end
            else if (active_q)
            begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == `FBPCC_STROBE_CYC)
                begin
                    flash_we_n_o <= 1'b1;
                    flash_oe_n_o <= 1'b1;
                    if (!wr_q)
                        rdata_o <= sync2_q;
                end
                if (cnt_q == `FBPCC_STROBE_CYC + 5'h02)
                begin
                    flash_ce_n_o <= 1'b1;
                    flash_data_oe_o <= 1'b0;
                    active_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule // fbpcc_bus_cycle

// >>> fbpcc_host.v
// Host sequencer that programs, erases, identifies and resets the flash.
`timescale 1ns/10ps
`include "fbpcc_defs.vh"
// Functional notes
// - Program starts with set-up write 40H.
// - Host times ten microsecond program pulse.
// - C0H ends program pulse, stages verify.
// - Wait six microseconds before verify read.
// - Retry mismatches, at most 25 pulses.
// - 00H returns device to array read.
// - Program-verify written before servicing interrupt.
// - Erase pulse timed, ended by A0H.
// - Wait for supply settle before commands.
// - Mask erased parallel devices with 00H; the host drives one device and writes no mask.
// - Issue reset sequence early at init; the host issues it only on an OP_RESET request.
// - Identification persists until next command.
// - Erase is two writes of 20H.
// - A0H with address ends erase, verifies.
module fbpcc_host
#(
    parameter PROG_CYC = `FBPCC_PROG_CYC,
    parameter ERASE_CYC = `FBPCC_ERASE_CYC,
    parameter RECOVERY_CYC = `FBPCC_RECOVERY_CYC
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire op_valid_i,
    input wire [1:0] op_code_i,
    input wire [15:0] op_addr_i,
    input wire [7:0] op_data_i,
    input wire irq_pending_i,
    output wire op_ready_o,
    output reg op_done_o,
    output reg op_fail_o,
    output reg [7:0] op_rdata_o,
    output reg [15:0] erase_fail_addr_o,
    output reg program_supply_high_level_o,
    output wire [15:0] flash_addr_o,
    output wire [7:0] flash_data_o,
    output wire flash_data_oe_o,
    input wire [7:0] flash_data_i,
    output wire flash_ce_n_o,
    output wire flash_we_n_o,
    output wire flash_oe_n_o
);
    // Operation codes on op_code_i.
    localparam OP_PROGRAM = 2'd0;
    localparam OP_ERASE = 2'd1;
    localparam OP_IDENT = 2'd2;
    localparam OP_RESET = 2'd3;
    localparam S_IDLE = 12'h001;
    localparam S_SETTLE = 12'h002;
    localparam S_W1 = 12'h004;
    localparam S_W2 = 12'h008;
    localparam S_PULSE = 12'h010;
    localparam S_VERIFY = 12'h020;
    localparam S_RECOV = 12'h040;
    localparam S_VREAD = 12'h080;
    localparam S_READCMD = 12'h100;
    localparam S_IDREAD = 12'h200;
    localparam S_DONE = 12'h400;
    localparam S_WAIT = 12'h800;
    localparam [23:0] PROG_CNT = PROG_CYC[23:0];
    localparam [23:0] ERASE_CNT = ERASE_CYC[23:0];
    localparam [23:0] RECOV_CNT = RECOVERY_CYC[23:0];
    localparam integer SETTLE_CYC = `FBPCC_SETTLE_CYC;
    localparam [23:0] SETTLE_CNT = SETTLE_CYC[23:0];
    reg [11:0] state_q;
    reg [11:0] after_q;
    reg [1:0] op_q;
    reg [15:0] addr_q;
    reg [7:0] data_q;
    reg [23:0] timer_q;
    reg [9:0] pulses_q;
    reg [7:0] cmd1_q;
    reg [7:0] cmd2_q;
    reg issued_q;
    reg bc_start;
    reg bc_write;
    reg [15:0] bc_addr;
    reg [7:0] bc_wdata;
    wire bc_busy;
    wire bc_done;
    wire [7:0] bc_rdata;
    assign op_ready_o = (state_q == S_IDLE);
    fbpcc_bus_cycle u_cycle
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(bc_start),
        .write_i(bc_write),
        .addr_i(bc_addr),
        .wdata_i(bc_wdata),
        .busy_o(bc_busy),
        .done_o(bc_done),
        .rdata_o(bc_rdata),
        .flash_addr_o(flash_addr_o),
        .flash_data_o(flash_data_o),
        .flash_data_oe_o(flash_data_oe_o),
        .flash_data_i(flash_data_i),
        .flash_ce_n_o(flash_ce_n_o),
        .flash_we_n_o(flash_we_n_o),
        .flash_oe_n_o(flash_oe_n_o)
    );
    // Bus cycle request for the current state; issued once per state visit.
    always @*
    begin
        bc_start = 1'b0;
        bc_write = 1'b1;
        bc_addr = addr_q;
        bc_wdata = 8'h00;
        if (!issued_q && !bc_busy)
        begin
            case (state_q)
                S_W1:
                begin
                    bc_start = 1'b1;
                    bc_wdata = cmd1_q;
                end
                S_W2:
                begin
                    bc_start = 1'b1;
                    bc_wdata = cmd2_q;
                end
                S_VERIFY:
                begin
                    bc_start = 1'b1;
                    bc_wdata = (op_q == OP_ERASE) ? `FBPCC_CMD_ERASE_VERIFY :
                        `FBPCC_CMD_PROG_VERIFY;
                end
                S_READCMD:
                begin
                    bc_start = 1'b1;
                    bc_wdata = `FBPCC_CMD_READ;
                end
                S_VREAD, S_IDREAD:
                begin
                    bc_start = 1'b1;
                    bc_write = 1'b0;
                end
                default:
                begin
                    bc_start = 1'b0;
                end
            endcase
        end
    end
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= S_IDLE;
            after_q <= S_IDLE;
            op_q <= OP_PROGRAM;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            timer_q <= 24'h00_0000;
            pulses_q <= 10'h000;
            cmd1_q <= 8'h00;
            cmd2_q <= 8'h00;
            issued_q <= 1'b0;
            op_done_o <= 1'b0;
            op_fail_o <= 1'b0;
            op_rdata_o <= 8'h00;
            erase_fail_addr_o <= 16'h0000;
            program_supply_high_level_o <= 1'b0;
        end
        else
        begin
            op_done_o <= 1'b0;
            if (bc_start)
                issued_q <= 1'b1;
            if (bc_done)
                issued_q <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (op_valid_i)
                    begin
                        op_q <= op_code_i;
                        addr_q <= op_addr_i;
                        data_q <= op_data_i;
                        pulses_q <= 10'h000;
                        op_fail_o <= 1'b0;
                        program_supply_high_level_o <= (op_code_i != OP_IDENT);
                        timer_q <= SETTLE_CNT;
                        case (op_code_i)
                            OP_PROGRAM:
                            begin
                                cmd1_q <= `FBPCC_CMD_SETUP_PROG;
                                cmd2_q <= op_data_i;
                            end
                            OP_ERASE:
                            begin
                                cmd1_q <= `FBPCC_CMD_SETUP_ERASE;
                                cmd2_q <= `FBPCC_CMD_SETUP_ERASE;
                            end
                            OP_IDENT:
                            begin
                                cmd1_q <= `FBPCC_CMD_AUTOSEL;
                                cmd2_q <= `FBPCC_CMD_AUTOSEL;
                            end
                            default:
                            begin
                                cmd1_q <= `FBPCC_CMD_RESET;
                                cmd2_q <= `FBPCC_CMD_RESET;
                            end
                        endcase
                        state_q <= S_SETTLE;
                    end
                end
                S_SETTLE:
                begin
                    if (timer_q == 24'h00_0000)
                        state_q <= S_W1;
                    else
                        timer_q <= timer_q - 24'h00_0001;
                end
                S_W1:
                begin
                    if (bc_done)
                        state_q <= (op_q == OP_IDENT) ? S_IDREAD : S_W2;
                end
                S_W2:
                begin
                    if (bc_done)
                    begin
                        if (op_q == OP_RESET)
                            state_q <= S_READCMD;
                        else
                        begin
                            // Pulse timed from bc_done of this write, two clocks after its rising strobe.
                            timer_q <= (op_q == OP_ERASE) ? ERASE_CNT : PROG_CNT;
                            pulses_q <= pulses_q + 10'h001;
                            state_q <= S_PULSE;
                        end
                    end
                end
                S_PULSE:
                begin
                    // A pending interrupt ends the pulse early so it never runs on.
                    if (timer_q == 24'h00_0000 || irq_pending_i)
                        state_q <= S_VERIFY;
                    else
                        timer_q <= timer_q - 24'h00_0001;
                end
                S_VERIFY:
                begin
                    if (bc_done)
                    begin
                        timer_q <= RECOV_CNT;
                        state_q <= S_RECOV;
                    end
                end
                S_RECOV:
                begin
                    if (timer_q == 24'h00_0000)
                        state_q <= S_VREAD;
                    else
                        timer_q <= timer_q - 24'h00_0001;
                end
                S_VREAD:
                begin
                    if (bc_done)
                    begin
                        op_rdata_o <= bc_rdata;
                        if (op_q == OP_ERASE)
                        begin
                            if (bc_rdata == `FBPCC_ERASED)
                            begin
                                if (addr_q == 16'hFFFF)
                                    state_q <= S_READCMD;
                                else
                                begin
                                    addr_q <= addr_q + 16'h0001;
                                    state_q <= S_VERIFY;
                                end
                            end
                            else if (pulses_q == `FBPCC_MAX_ERASE_PULSES)
                            begin
                                erase_fail_addr_o <= addr_q;
                                op_fail_o <= 1'b1;
                                state_q <= S_READCMD;
                            end
                            else
                            begin
                                // Verification resumes at the failing address.
                                erase_fail_addr_o <= addr_q;
                                state_q <= S_W1;
                            end
                        end
                        else if (bc_rdata == data_q)
                            state_q <= S_READCMD;
                        else if (pulses_q == {5'h00, `FBPCC_MAX_PROG_PULSES})
                        begin
                            op_fail_o <= 1'b1;
                            state_q <= S_READCMD;
                        end
                        else
                            state_q <= S_W1;
                    end
                end
                S_READCMD:
                begin
                    if (bc_done)
                    begin
                        after_q <= S_DONE;
                        state_q <= S_DONE;
                    end
                end
                S_IDREAD:
                begin
                    if (bc_done)
                    begin
                        op_rdata_o <= bc_rdata;
                        state_q <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    program_supply_high_level_o <= 1'b0;
                    op_done_o <= 1'b1;
                    state_q <= S_WAIT;
                end
                S_WAIT:
                begin
                    state_q <= after_q == S_DONE ? S_IDLE : S_IDLE;
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // fbpcc_host

// >>> fbpcc_host_props.sv
// Concurrent checks on the ports of the flash host controller.
`timescale 1ns/10ps
module fbpcc_host_props
#(
    parameter int PROG_CYC = 20,
    parameter int ERASE_CYC = 50,
    parameter int RECOVERY_CYC = 10
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire logic [1:0] op_code_i,
    input wire logic irq_pending_i,
    input wire logic op_ready_o,
    input wire logic op_done_o,
    input wire logic program_supply_high_level_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic [7:0] flash_data_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_we_n_o,
    input wire logic flash_oe_n_o
);
    logic [23:0] gap_q;
    logic [5:0] sup_q;
    logic [7:0] wr1_q;
    logic [7:0] wr2_q;
    logic [4:0] pcnt_q;
    logic [1:0] code_q;
    logic irq_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // The gap counter saturates so that a stalled bus never wraps into a false failure.
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            {gap_q, sup_q, wr1_q, wr2_q, pcnt_q, code_q, irq_q} <= '0;
        else
        begin
            gap_q <= $rose(flash_we_n_o) ? '0 : gap_q + 24'(~&gap_q);
            sup_q <= program_supply_high_level_o ? sup_q + 6'(~&sup_q) : '0;
            irq_q <= $rose(flash_we_n_o) ? 1'b0 : (irq_q | irq_pending_i);
            if ($rose(flash_we_n_o))
            begin
                wr1_q <= flash_data_o;
                wr2_q <= wr1_q;
            end
            if (op_valid_i && op_ready_o)
            begin
                code_q <= op_code_i;
                pcnt_q <= '0;
            end
            else if ($rose(flash_we_n_o) && flash_data_o == 8'hC0)
                pcnt_q <= pcnt_q + 5'h01;
        end
    end
    a_settle_first: assert property ($fell(flash_ce_n_o) && program_supply_high_level_o
        |-> sup_q >= 6'h18) else $error("Strobe before the supply settled.");
    a_strobe_hold: assert property (!flash_we_n_o && $past(!flash_we_n_o)
        |-> $stable(flash_addr_o) && $stable(flash_data_o)) else $error("Write bus moved.");
    a_we_oe_apart: assert property (!(!flash_we_n_o && !flash_oe_n_o))
        else $error("Write and read strobes overlap.");
    a_prog_pulse: assert property ($rose(flash_we_n_o) && flash_data_o == 8'hC0
        && !irq_q && !irq_pending_i |-> gap_q >= PROG_CYC) else $error("Program pulse short.");
    a_erase_pulse: assert property ($rose(flash_we_n_o) && flash_data_o == 8'hA0
        && wr1_q == 8'h20 && !irq_q && !irq_pending_i |-> gap_q >= ERASE_CYC)
        else $error("Erase pulse short.");
    a_verify_order: assert property ($rose(flash_we_n_o) && flash_data_o == 8'hC0
        |-> wr2_q == 8'h40) else $error("Verify without set-up and program.");
    a_erase_order: assert property ($rose(flash_we_n_o) && flash_data_o == 8'hA0
        |-> (wr1_q == 8'h20 && wr2_q == 8'h20) || wr1_q == 8'hA0)
        else $error("Erase verify out of order.");
    a_recovery_wait: assert property ($fell(flash_oe_n_o) && (wr1_q == 8'hC0
        || wr1_q == 8'hA0) |-> gap_q >= RECOVERY_CYC) else $error("Read too soon.");
    a_pulse_limit: assert property ($rose(flash_we_n_o) && flash_data_o == 8'hC0
        |-> pcnt_q < 5'h19) else $error("Too many program pulses.");
    a_read_restore: assert property ($rose(op_done_o) && code_q != 2'h2
        |-> wr1_q == 8'h00) else $error("Operation ended without read command.");
    a_irq_ends: assert property (wr2_q == 8'h40 && flash_ce_n_o && irq_pending_i
        |-> ##[1:4] $fell(flash_we_n_o)) else $error("Interrupt left pulse running.");
    c_retry: cover property ($rose(flash_we_n_o) && flash_data_o == 8'hC0 && pcnt_q == 5'h02);
    c_limit: cover property ($rose(flash_we_n_o) && flash_data_o == 8'hC0 && pcnt_q == 5'h18);
    c_irq: cover property (wr2_q == 8'h40 && irq_pending_i);
    c_erase: cover property ($rose(flash_we_n_o) && flash_data_o == 8'hA0 && wr1_q == 8'h20);
endmodule // fbpcc_host_props
bind fbpcc_host fbpcc_host_props
#(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC), .RECOVERY_CYC(RECOVERY_CYC)) i_props (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .irq_pending_i(irq_pending_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o),
    .program_supply_high_level_o(program_supply_high_level_o), .flash_addr_o(flash_addr_o),
    .flash_data_o(flash_data_o), .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_oe_n_o(flash_oe_n_o)
);

// >>> fbpcc_flash_model.sv
// Behavioural model of the byte-wide flash device behind the host pins.
`timescale 1ns/10ps
module fbpcc_flash_model
#(
    // Identification values are arbitrary.
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] DEVICE_CODE = 8'hC3,
    parameter int REC_NS = 40
)
(
    input wire logic [15:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic supply_i,
    input wire logic [4:0] need_i,
    output logic [7:0] data_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] pd, last, val;
    logic [15:0] la, pa;
    logic [3:0] state;
    logic early;
    int pulse_cnt;
    realtime wr_t;
    initial
    begin
        state = 4'h0;
        pulse_cnt = 0;
        wr_t = 0;
        early = 1'b0;
        last = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hFF;
    end
    always @(negedge we_n_i)
        if (!ce_n_i)
            la = addr_i;
    // A byte only sticks after need_i pulses, so the host's retry loop is exercised.
    always @(posedge we_n_i)
    begin
        if (!ce_n_i)
        begin
            wr_t = $realtime;
            if ((state == 4'h1 || state == 4'h4) && data_i == 8'hFF)
                state = 4'h8;
            else if (state == 4'h8 && data_i == 8'hFF)
                state = 4'h0;
            else if (state == 4'h1)
            begin
                pa = la;
                pd = data_i;
                state = 4'h2;
            end
            else if (state == 4'h4 && data_i == 8'h20)
                state = 4'h5;
            else if (data_i == 8'h40)
            begin
                if (state != 4'h3)
                    pulse_cnt = 0;
                state = 4'h1;
            end
            else if (data_i == 8'h20)
                state = 4'h4;
            else if (data_i == 8'hC0 && state == 4'h2)
            begin
                pulse_cnt++;
                if (supply_i && pulse_cnt >= need_i)
                    mem[pa] = mem[pa] & pd;
                state = 4'h3;
            end
            else if (data_i == 8'hA0 && (state == 4'h5 || state == 4'h6))
            begin
                if (state == 4'h5 && supply_i)
                    for (int i = 0; i < 65536; i++)
                        mem[i] = 8'hFF;
                pa = la;
                state = 4'h6;
            end
            else if (data_i == 8'h00)
                state = 4'h0;
            else if (data_i == 8'h80 || data_i == 8'h90)
                state = 4'h7;
        end
    end
    always @(negedge oe_n_i)
        early = ($realtime - wr_t) < REC_NS;
    always @(posedge oe_n_i)
        last = data_o;
    always @*
    begin
        case (state)
            4'h7: val = addr_i == 16'h0000 ? MAKER_CODE : DEVICE_CODE;
            4'h3, 4'h6: val = mem[pa];
            default: val = mem[addr_i];
        endcase
        if (ce_n_i || oe_n_i || !we_n_i)
            data_o = ~last;
        else if (early && (state == 4'h3 || state == 4'h6))
            data_o = ~val;
        else
            data_o = val;
    end
endmodule // fbpcc_flash_model

// >>> testbench.sv
// Self-checking bench for the flash host controller.
`timescale 1ns/10ps
module testbench;
    typedef struct {logic [1:0] c; logic [15:0] a; logic [7:0] d; logic [4:0] n; logic [7:0] r;}
        fbpcc_row_t;
    // Identification values are arbitrary.
    localparam logic [7:0] MK = 8'h5A;
    localparam logic [7:0] DV = 8'hC3;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic op_valid_i = 1'b0;
    logic [1:0] op_code_i = 2'h0;
    logic [15:0] op_addr_i = 16'h0000;
    logic [7:0] op_data_i = 8'h00;
    logic irq_pending_i = 1'b0;
    logic [4:0] need = 5'h01;
    wire op_ready_o, op_done_o, op_fail_o, sup_o, oe_o, ce_n, we_n, oe_n;
    wire [7:0] op_rdata_o, hd_o, dev_d;
    wire [15:0] ea_o, fa_o;
    wire [7:0] fd_i = oe_o ? hd_o : dev_d;
    int bad_count = 0;
    int checked = 0;
    fbpcc_row_t rows [6] = '{'{2'h0, 16'h0010, 8'h5A, 5'h01, 8'h5A},
        '{2'h0, 16'h0011, 8'h33, 5'h03, 8'h33}, '{2'h2, 16'h0000, 8'h00, 5'h01, MK},
        '{2'h2, 16'h0001, 8'h00, 5'h01, DV}, '{2'h0, 16'h0012, 8'hA5, 5'h01, 8'hA5},
        '{2'h1, 16'hFFF0, 8'h00, 5'h01, 8'hFF}};
    fbpcc_host #(.PROG_CYC(20), .ERASE_CYC(50), .RECOVERY_CYC(10)) i_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
        .op_addr_i(op_addr_i), .op_data_i(op_data_i), .irq_pending_i(irq_pending_i),
        .op_ready_o(op_ready_o), .op_done_o(op_done_o), .op_fail_o(op_fail_o),
        .op_rdata_o(op_rdata_o), .erase_fail_addr_o(ea_o), .program_supply_high_level_o(sup_o),
        .flash_addr_o(fa_o), .flash_data_o(hd_o), .flash_data_oe_o(oe_o), .flash_data_i(fd_i),
        .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n));
    fbpcc_flash_model #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .REC_NS(40)) i_flash (
        .addr_i(fa_o), .data_i(hd_o), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .supply_i(sup_o), .need_i(need), .data_o(dev_d));
    initial
    begin
        forever #2 clock_i = ~clock_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Counts: checked=%0d bad=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic run_op(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (op_ready_o !== 1'b1)
            @(negedge clock_i);
        op_code_i = c;
        op_addr_i = a;
        op_data_i = d;
        op_valid_i = 1'b1;
        @(negedge clock_i);
        op_valid_i = 1'b0;
        while (op_done_o !== 1'b1 && n < 20000)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 20000)
            bad_count++;
        repeat (2) @(negedge clock_i);
    endtask
    initial
    begin
        #200000;
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            need = rows[i].n;
            run_op(rows[i].c, rows[i].a, rows[i].d);
            chk(op_rdata_o, rows[i].r);
            chk(op_fail_o, 1'b0);
            if (rows[i].c == 2'h0)
                chk(i_flash.mem[rows[i].a], rows[i].d);
            if (rows[i].c == 2'h0)
                chk(16'(i_flash.pulse_cnt), rows[i].n);
            if (rows[i].c == 2'h1)
                chk(i_flash.mem[16'h0010], 8'hFF);
            if (rows[i].c == 2'h1)
                chk(ea_o, 16'h0000);
            $display("Row %0d done", i);
        end
        need = 5'h1A;
        run_op(2'h0, 16'h0030, 8'h0F);
        chk(op_fail_o, 1'b1);
        chk(16'(i_flash.pulse_cnt), 16'h0019);
        $display("Pulse limit test done");
        need = 5'h01;
        fork
            run_op(2'h0, 16'h0040, 8'h77);
            begin
                wait (i_flash.state == 4'h2);
                repeat (8) @(negedge clock_i);
                irq_pending_i = 1'b1;
                repeat (3) @(negedge clock_i);
                irq_pending_i = 1'b0;
                repeat (16) @(negedge clock_i);
                chk(i_flash.state, 4'h3);
            end
        join
        chk(i_flash.mem[16'h0040], 8'h77);
        $display("Interrupt test done");
        op_code_i = 2'h0;
        op_addr_i = 16'h0050;
        op_data_i = 8'h12;
        op_valid_i = 1'b1;
        @(negedge clock_i);
        op_valid_i = 1'b0;
        wait (i_flash.state == 4'h1);
        @(negedge clock_i);
        rst_n_i = 1'b0;
        @(negedge clock_i);
        chk({op_ready_o, we_n, ce_n, oe_n, sup_o}, 5'h1E);
        rst_n_i = 1'b1;
        run_op(2'h3, 16'h0000, 8'h00);
        chk(i_flash.state, 4'h0);
        chk(i_flash.mem[16'h0050], 8'hFF);
        $display("Abort test done");
        close_out();
    end
endmodule // testbench
